/* File: ext_pads.sv */
// Purpose: far-side terminal model: loads, weak bias, outside drivers
// Assumes: testbench picks which terminals are driven from outside
// Notes:   top terminal carries a free square wave, floating ones toggle
`timescale 1ns/1ps
module ext_pads #(
    parameter int unsigned N    = 16,
    parameter int unsigned HALF = 5
) (
    input  wire logic         clk,
    input  wire logic [N-1:0] pad_out,
    input  wire logic [N-1:0] pad_oe_n,
    input  wire logic [N-1:0] pull_up_en,
    input  wire logic [N-1:0] pull_down_en,
    input  wire logic [N-1:0] drv_en,
    input  wire logic [N-1:0] drv_val,
    output logic      [N-1:0] pad_in
);
    logic       sq  = 1'b0;
    logic       flt = 1'b0;
    logic [7:0] cnt = 8'h00;
    always @(posedge clk) begin
        flt <= ~flt;
        cnt <= (cnt == 8'(HALF - 1)) ? 8'h00 : cnt + 8'h01;
        if (cnt == 8'(HALF - 1)) begin
            sq <= ~sq;
        end
    end
    // block drive wins, then outside driver, then weak bias, else a level that toggles every clock
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (!pad_oe_n[i]) begin
                pad_in[i] = pad_out[i];
            end else if (drv_en[i]) begin
                pad_in[i] = (i == N - 1) ? sq : drv_val[i];
            end else if (pull_up_en[i] || pull_down_en[i]) begin
                pad_in[i] = pull_up_en[i];
            end else begin
                pad_in[i] = flt;
            end
        end
    end
endmodule

/* File: io_cfg_chk_sva.sv */
// Purpose: port-level assertions for the terminal configuration block
// Assumes: single clock, synchronous active-high reset
// Notes:   bound to the top module by the statement at the foot
`timescale 1ns/1ps
module io_cfg_chk
    import io_cfg_pkg::*;
#(
    parameter int unsigned NUM_TERM = 16
) (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic [7:0]           paddr,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [NUM_TERM-1:0]  pad_oe_n,
    input wire logic [NUM_TERM-1:0]  pull_up_en,
    input wire logic [NUM_TERM-1:0]  pull_down_en,
    input wire logic [NUM_TERM-1:0]  analog_en,
    input wire logic [NUM_TERM-1:0]  edge_pending,
    input wire logic [NUM_TICKS-1:0] tick_pending
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // =================================================================
    // helpers
    logic acc_wr;
    assign acc_wr = psel && penable && pwrite && pready;
    sequence s_setup;
        psel && !penable;
    endsequence
    // =================================================================
    // bus timing
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("no answer one cycle after setup");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_unmapped: assert property (s_setup |=> pslverr == ($past(paddr) >= 8'he0))
        else $error("error flag does not match address decode");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable))
        else $error("read data changed outside a setup");
    // =================================================================
    // terminal outputs and pending flags
    a_analog_undriven: assert property ((analog_en & ~pad_oe_n) == '0)
        else $error("analog terminal driven");
    a_bias_exclusive: assert property ((pull_up_en & pull_down_en) == '0)
        else $error("both pulls on one terminal");
    a_edge_sticky: assert property (
        |($past(edge_pending) & ~edge_pending) |-> $past(acc_wr && paddr == EDGE_ST_OFS))
        else $error("edge flag dropped without clear");
    a_tick_sticky: assert property (
        |($past(tick_pending) & ~tick_pending) |-> $past(acc_wr && paddr == TICK_ST_OFS))
        else $error("tick flag dropped without clear");
endmodule

bind io_config_edge_irq_tick io_cfg_chk #(.NUM_TERM(NUM_TERM)) io_cfg_chk_i (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_oe_n(pad_oe_n), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .analog_en(analog_en), .edge_pending(edge_pending), .tick_pending(tick_pending));

/* File: io_cfg_pkg.sv */
// Purpose: shared constants and types for the terminal configuration block
// Assumes: 32-bit APB register bus, 10 MHz system clock
// Notes:   byte offsets are word aligned, narrow registers read zero above
package io_cfg_pkg;

    // ==================================================================
    // register map (byte addresses)
    localparam logic [7:0] CFG_BASE      = 8'h00;
    localparam logic [7:0] OPT_BASE      = 8'h40;
    localparam logic [7:0] RES_BASE      = 8'h80;
    localparam logic [7:0] OUT_OFS       = 8'hc0;
    localparam logic [7:0] IN_OFS        = 8'hc4;
    localparam logic [7:0] EDGE_ST_OFS   = 8'hc8;
    localparam logic [7:0] TICK_ST_OFS   = 8'hcc;
    localparam logic [7:0] TICK_BASE     = 8'hd0;

    // ==================================================================
    // configuration register fields
    localparam int unsigned CFG_MODE_LSB = 0;
    localparam int unsigned CFG_BIAS_LSB = 3;
    localparam int unsigned CFG_OD_BIT   = 5;
    localparam int unsigned CFG_EVT_LSB  = 6;
    localparam logic [7:0]  CFG_RESET    = 8'h00;
    localparam logic [16:0] OPT_RESET    = 17'h00000;
    localparam logic [30:0] TICK_RESET   = 31'h00000000;

    typedef enum logic [2:0] {
        mode_inactive, analog_sense_mode, digital_input_mode, frequency_measure_mode,
        period_measure_mode, pulse_count_mode, digital_output_mode
    } mode_t;

    typedef enum logic [1:0] {bias_none, bias_pull_up, bias_pull_down} bias_t;

    typedef enum logic [1:0] {
        event_off, rising_edge_event, falling_edge_event, any_edge_event
    } event_mode_t;

    // ==================================================================
    // limits and timing
    localparam logic [16:0] GATE_MIN_MS      = 17'd10;
    localparam logic [16:0] GATE_MAX_MS      = 17'd100000;
    localparam logic [16:0] GATE_DEFAULT_MS  = 17'd1000;
    localparam logic [16:0] AVG_MIN          = 17'd1;
    localparam logic [16:0] AVG_MAX          = 17'd10000;
    localparam logic [16:0] AVG_DEFAULT      = 17'd1;
    localparam int unsigned MAX_EVENT_TERMS  = 10;
    localparam int unsigned NUM_TICKS        = 4;
    localparam logic [47:0] MS_PER_S         = 48'd1000;
    localparam logic [47:0] RES_SCALE        = 48'd1000;
    localparam int unsigned CLK_PERIOD_NS    = 100;
    localparam int unsigned MS_NS            = 1000000;
    localparam int unsigned CYCLES_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;

endpackage

/* File: io_config_edge_irq_tick.sv */
// Purpose: per-terminal mode, bias, drive, measurement, edge events, tick timers
// Assumes: APB slave with no wait states; pad inputs are asynchronous
// Notes:   results and event flags are polled by software
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps

module io_config_edge_irq_tick
    import io_cfg_pkg::*;
#(
    parameter int unsigned NUM_TERM      = 16,
    parameter int unsigned CYCLES_PER_MS = CYCLES_PER_MS_DEF
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic [7:0]          paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [NUM_TERM-1:0] pad_in,
    output logic      [NUM_TERM-1:0] pad_out,
    output logic      [NUM_TERM-1:0] pad_oe_n,
    output logic      [NUM_TERM-1:0] pull_up_en,
    output logic      [NUM_TERM-1:0] pull_down_en,
    output logic      [NUM_TERM-1:0] analog_en,
    output logic      [NUM_TERM-1:0] edge_pending,
    output logic      [NUM_TICKS-1:0] tick_pending
);

    // ==================================================================
    // elaboration checks
    // terminal index decode is four bits wide
    if (NUM_TERM < 1 || NUM_TERM > 16) begin : g_bad_terms
        $error("NUM_TERM must be 1 to 16");
    end
    // millisecond divider is sixteen bits wide
    if (CYCLES_PER_MS < 1 || CYCLES_PER_MS > 65535) begin : g_bad_cpm
        $error("CYCLES_PER_MS must be 1 to 65535");
    end
    // occupancy counter is five bits wide
    if (MAX_EVENT_TERMS > 16) begin : g_bad_evt
        $error("MAX_EVENT_TERMS must be at most 16");
    end

    localparam logic [4:0]  NT      = 5'(NUM_TERM);
    localparam logic [4:0]  MAX_EVT = 5'(MAX_EVENT_TERMS);
    localparam logic [15:0] CPM     = 16'(CYCLES_PER_MS);

    // ==================================================================
    // state
    logic [7:0]           cfg_q    [NUM_TERM];
    logic [16:0]          opt_q    [NUM_TERM];
    logic [31:0]          res_q    [NUM_TERM];
    logic [30:0]          tick_per_q [NUM_TICKS];
    logic [NUM_TERM-1:0]  out_q;
    logic [NUM_TERM-1:0]  lvl_q;
    logic [31:0]          prdata_q;
    logic                 pready_q;
    logic                 pslverr_q;
    logic [15:0]          ms_cnt_q;
    logic                 ms_tick_q;

    // ==================================================================
    // apb decode
    wire        acc       = psel & penable & pready_q;
    wire        wr        = acc & pwrite;
    wire [1:0]  region    = paddr[7:6];
    wire [3:0]  idx       = paddr[5:2];
    wire        term_ok   = ({1'b0, idx} < NT);
    wire        is_term   = (region != 2'd3);
    wire        is_misc   = (region == 2'd3) & ~idx[3];
    wire        mapped    = (is_term & term_ok) | is_misc;
    wire        wr_cfg    = wr & (region == 2'd0) & term_ok;
    wire        wr_opt    = wr & (region == 2'd1) & term_ok;
    wire        wr_out    = wr & (paddr == OUT_OFS);
    wire        wr_edge   = wr & (paddr == EDGE_ST_OFS);
    wire        wr_tickst = wr & (paddr == TICK_ST_OFS);
    wire        wr_tick   = wr & is_misc & idx[2];
    wire [1:0]  tick_idx  = idx[1:0];
    // out-of-range index folds to terminal 0; writes and reads are masked
    wire [3:0]  tsel      = term_ok ? idx : 4'h0;

    // ==================================================================
    // edge-event occupancy limit
    logic [4:0] evt_active;
    always_comb begin
        evt_active = 5'd0;
        for (int k = 0; k < NUM_TERM; k++) begin
            evt_active = evt_active + {4'd0, (cfg_q[k][CFG_EVT_LSB+:2] != 2'd0)};
        end
    end

    wire [7:0] cur_cfg   = cfg_q[tsel];
    wire       new_evt   = (pwdata[CFG_EVT_LSB+:2] != 2'd0);
    wire       had_evt   = (cur_cfg[CFG_EVT_LSB+:2] != 2'd0);
    // an event request past the limit is stored with events off
    wire       evt_room  = had_evt | (evt_active < MAX_EVT);
    wire [1:0] evt_field = (new_evt & evt_room) ? pwdata[CFG_EVT_LSB+:2] : 2'd0;
    // any event enable forces digital input mode
    wire [2:0] mode_fld  = (evt_field != 2'd0) ? 3'(digital_input_mode)
                                               : pwdata[CFG_MODE_LSB+:3];
    wire [7:0] cfg_wval  = {evt_field, pwdata[CFG_OD_BIT], pwdata[CFG_BIAS_LSB+:2], mode_fld};

    // ==================================================================
    // read mux
    wire [31:0] rd_cfg  = {24'h000000, cur_cfg};
    wire [31:0] rd_opt  = {15'h0000, opt_q[tsel]};
    wire [31:0] rd_res  = res_q[tsel];
    wire [31:0] rd_tick = {1'b0, tick_per_q[tick_idx]};
    wire [31:0] rd_misc = (paddr == OUT_OFS)     ? 32'(out_q) :
                          (paddr == IN_OFS)      ? 32'(lvl_q) :
                          (paddr == EDGE_ST_OFS) ? 32'(edge_pending) :
                          (paddr == TICK_ST_OFS) ? 32'(tick_pending) :
                          rd_tick;
    // unmapped or out-of-range addresses read zero
    wire [31:0] rd_data = ~mapped          ? 32'h00000000 :
                          (region == 2'd0) ? rd_cfg :
                          (region == 2'd1) ? rd_opt :
                          (region == 2'd2) ? rd_res : rd_misc;

    // ==================================================================
    // bus response, no wait states; every output is a flop
    // read data is latched at setup and stands until the next setup
    always_ff @(posedge clk) begin
        if (rst) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel & ~penable;
            prdata_q  <= (psel & ~penable) ? rd_data : prdata_q;
            pslverr_q <= psel & ~penable & ~mapped;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ==================================================================
    // configuration registers
    always_ff @(posedge clk) begin
        if (rst) begin
            out_q <= '0;
            for (int k = 0; k < NUM_TERM; k++) begin
                cfg_q[k] <= CFG_RESET;
                opt_q[k] <= OPT_RESET;
            end
        end else begin
            if (wr_cfg) begin
                cfg_q[tsel] <= cfg_wval;
            end
            if (wr_opt) begin
                opt_q[tsel] <= pwdata[16:0];
            end
            // levels matter only on terminals in output mode
            if (wr_out) begin
                out_q <= pwdata[NUM_TERM-1:0];
            end
        end
    end

    // ==================================================================
    // millisecond time base
    // one-cycle strobe every CYCLES_PER_MS clocks paces all ms timing
    always_ff @(posedge clk) begin
        if (rst) begin
            ms_cnt_q  <= 16'h0000;
            ms_tick_q <= 1'b0;
        end else begin
            ms_tick_q <= (ms_cnt_q == CPM - 16'd1);
            ms_cnt_q  <= (ms_cnt_q == CPM - 16'd1) ? 16'h0000 : ms_cnt_q + 16'd1;
        end
    end

    // ==================================================================
    // per-terminal logic
    for (genvar i = 0; i < NUM_TERM; i++) begin : g_term
        logic [2:0]  sync_q;
        logic [31:0] cnt_q;
        logic [31:0] tim_q;
        logic        armed_q;
        logic        pend_q;
        logic        po_q, oe_n_q, pu_q, pd_q, an_q;

        wire  [4:0]  my_idx  = 5'(i);
        wire         restart = (wr_cfg | wr_opt) & ({1'b0, idx} == my_idx);
        wire  [2:0]  mode    = cfg_q[i][CFG_MODE_LSB+:3];
        wire  [1:0]  bias    = cfg_q[i][CFG_BIAS_LSB+:2];
        wire         od      = cfg_q[i][CFG_OD_BIT];
        wire  [1:0]  emode   = cfg_q[i][CFG_EVT_LSB+:2];
        wire  [16:0] opt     = opt_q[i];
        // sync_q[1:0] synchronise the pin; sync_q[2] only delays for edges
        wire         rise    = sync_q[1] & ~sync_q[2];
        wire         fall    = ~sync_q[1] & sync_q[2];
        wire         is_freq = (mode == 3'(frequency_measure_mode));
        wire         is_per  = (mode == 3'(period_measure_mode));
        wire         is_cnt  = (mode == 3'(pulse_count_mode));
        wire         is_out  = (mode == 3'(digital_output_mode));
        wire         is_in   = (mode == 3'(digital_input_mode));

        // gate and averaging count, defaults and clamps
        wire  [16:0] gate = (opt == 17'd0)       ? GATE_DEFAULT_MS :
                            (opt < GATE_MIN_MS)  ? GATE_MIN_MS :
                            (opt > GATE_MAX_MS)  ? GATE_MAX_MS : opt;
        wire  [16:0] avg  = (opt == 17'd0)       ? AVG_DEFAULT :
                            (opt > AVG_MAX)      ? AVG_MAX : opt;
        wire         gate_end = ms_tick_q & (tim_q[16:0] + 17'd1 >= gate);
        wire         per_end  = rise & armed_q & (cnt_q[16:0] + 17'd1 >= avg);

        // scaled results
        wire  [47:0] f_num = 48'(cnt_q) * MS_PER_S;
        wire  [47:0] f_res = f_num / 48'(gate);
        wire  [47:0] p_num = 48'(tim_q + 32'd1) * RES_SCALE;
        wire  [47:0] p_den = 48'(avg) * 48'(CPM);
        wire  [47:0] p_res = p_num / p_den;

        wire         evt = ((emode == 2'(rising_edge_event))  & rise) |
                           ((emode == 2'(falling_edge_event)) & fall) |
                           ((emode == 2'(any_edge_event))     & (rise | fall));
        wire         clr = wr_edge & pwdata[i];

        always_ff @(posedge clk) begin
            if (rst) begin
                sync_q <= 3'b000;
            end else begin
                sync_q <= {sync_q[1:0], pad_in[i]};
            end
        end

        always_ff @(posedge clk) begin
            if (rst || restart) begin
                cnt_q   <= 32'h00000000;
                tim_q   <= 32'h00000000;
                armed_q <= 1'b0;
                res_q[i] <= 32'h00000000;
            end else if (is_freq) begin
                // first gate after a restart may be up to one ms short
                cnt_q <= gate_end ? {31'h0, rise} : cnt_q + {31'h0, rise};
                tim_q <= gate_end ? 32'h00000000 : tim_q + {31'h0, ms_tick_q};
                if (gate_end) begin
                    res_q[i] <= f_res[31:0];
                end
            end else if (is_per) begin
                // timing starts at the first rising edge after a restart
                armed_q <= armed_q | rise;
                tim_q   <= (per_end || !armed_q) ? 32'h00000000 : tim_q + 32'd1;
                cnt_q   <= per_end ? 32'h00000000 : cnt_q + {31'h0, rise & armed_q};
                if (per_end) begin
                    res_q[i] <= p_res[31:0];
                end
            end else if (is_cnt) begin
                // count wraps, never saturates
                cnt_q    <= cnt_q + {31'h0, rise};
                res_q[i] <= cnt_q + {31'h0, rise};
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                pend_q <= 1'b0;
                po_q   <= 1'b0;
                oe_n_q <= 1'b1;
                pu_q   <= 1'b0;
                pd_q   <= 1'b0;
                an_q   <= 1'b0;
            end else begin
                // a new event wins over a clear in the same cycle
                pend_q <= evt | (pend_q & ~clr);
                // open drain high floats: enable off, drive value low
                po_q   <= is_out & ~od & out_q[i];
                oe_n_q <= ~(is_out & (~od | ~out_q[i]));
                pu_q   <= is_in & (bias == 2'(bias_pull_up));
                pd_q   <= is_in & (bias == 2'(bias_pull_down));
                an_q   <= (mode == 3'(analog_sense_mode));
            end
        end

        assign lvl_q[i]        = sync_q[1];
        assign pad_out[i]      = po_q;
        assign pad_oe_n[i]     = oe_n_q;
        assign pull_up_en[i]   = pu_q;
        assign pull_down_en[i] = pd_q;
        assign analog_en[i]    = an_q;
        assign edge_pending[i] = pend_q;
    end

    // ==================================================================
    // tick timers
    for (genvar t = 0; t < NUM_TICKS; t++) begin : g_tick
        logic [30:0] ms_q;
        logic        pend_q;

        wire         sel      = wr_tick & (tick_idx == 2'(t));
        wire         enabled  = (tick_per_q[t] != 31'h00000000);
        wire         fire     = enabled & ms_tick_q & (ms_q + 31'd1 >= tick_per_q[t]);
        wire         clr      = wr_tickst & pwdata[t];

        always_ff @(posedge clk) begin
            if (rst) begin
                tick_per_q[t] <= TICK_RESET;
                ms_q          <= 31'h00000000;
                pend_q        <= 1'b0;
            end else begin
                // a period write restarts the count, first interval runs short
                if (sel) begin
                    tick_per_q[t] <= pwdata[30:0];
                end
                ms_q   <= (sel || fire || !enabled) ? 31'h00000000
                                                    : ms_q + {30'h0, ms_tick_q};
                // a new tick wins over a clear in the same cycle
                pend_q <= fire | (pend_q & ~clr);
            end
        end

        assign tick_pending[t] = pend_q;
    end

endmodule

/* File: testbench.sv */
// Purpose: directed register-level test of the terminal configuration block
// Assumes: ms shortened to 10 clocks; square wave of 10 clocks on terminal 15
// Notes:   frequency reads 1000 Hz and period 1000 thousandths of a ms
`timescale 1ns/1ps
module testbench
    import io_cfg_pkg::*;
;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] pad_in, pad_out, pad_oe_n, pull_up_en, pull_down_en, analog_en;
    logic [15:0] edge_pending, drv_en, drv_val;
    logic [3:0]  tick_pending;
    int          n_errors = 0;
    int          n_tests = 0;
    time         t1, t2;
    io_config_edge_irq_tick #(.NUM_TERM(16), .CYCLES_PER_MS(10)) io_config_edge_irq_tick_i (
        .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .analog_en(analog_en),
        .edge_pending(edge_pending), .tick_pending(tick_pending));
    ext_pads #(.N(16), .HALF(5)) ext_pads_i (
        .clk(clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .drv_en(drv_en), .drv_val(drv_val), .pad_in(pad_in));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // =================================================================
    // tasks
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_errors++;
            report_and_stop();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never reassigns psel in this step
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    task automatic wait_tick(output time t);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (tick_pending[0] !== 1'b1 && k < 200);
        if (k >= 200) begin
            n_errors++;
            report_and_stop();
        end
        t = $time;
    endtask
    // =================================================================
    // main sequence
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        drv_en = 16'hfff8;
        drv_val = 16'h0000;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(CFG_BASE, 32'h0);
        rd(OPT_BASE + 8'h04, 32'h0);
        rd(TICK_BASE, 32'h0);
        apb(1'b0, 8'he0, 32'h0);
        chk({rerr, rdat[30:0]}, 32'h80000000);
        wr(CFG_BASE + 8'h08, 32'h01);
        @(posedge clk);
        chk({30'h0, analog_en[2], pad_oe_n[2]}, 32'h3);
        wr(CFG_BASE + 8'h08, 32'h0a);
        @(posedge clk);
        chk({30'h0, pull_up_en[2], pull_down_en[2]}, 32'h2);
        wr(CFG_BASE, 32'h06);
        wr(CFG_BASE + 8'h04, 32'h26);
        wr(OUT_OFS, 32'h3);
        @(posedge clk);
        chk({28'h0, pad_oe_n[1:0], pad_out[1:0]}, 32'h9);
        repeat (3) @(posedge clk);
        apb(1'b0, IN_OFS, 32'h0);
        chk({31'h0, rdat[0]}, 32'h1);
        wr(OUT_OFS, 32'h0);
        @(posedge clk);
        chk({28'h0, pad_oe_n[1:0], pad_out[1:0]}, 32'h0);
        wr(CFG_BASE + 8'h0c, 32'h50);
        rd(CFG_BASE + 8'h0c, 32'h52);
        chk({31'h0, pull_down_en[3]}, 32'h1);
        wr(CFG_BASE + 8'h10, 32'h80);
        wr(CFG_BASE + 8'h14, 32'hc0);
        for (int i = 6; i < 14; i++) wr(CFG_BASE + 8'(4 * i), 32'h40);
        apb(1'b0, CFG_BASE + 8'h34, 32'h0);
        chk({30'h0, rdat[7:6]}, 32'h0);
        repeat (6) @(posedge clk);
        wr(EDGE_ST_OFS, 32'hffff);
        rd(EDGE_ST_OFS, 32'h0);
        drv_val[5:3] <= 3'b111;
        repeat (6) @(posedge clk);
        rd(EDGE_ST_OFS, 32'h28);
        wr(EDGE_ST_OFS, 32'hffff);
        drv_val[5:3] <= 3'b000;
        repeat (6) @(posedge clk);
        rd(EDGE_ST_OFS, 32'h30);
        wr(CFG_BASE + 8'h38, 32'h05);
        for (int i = 0; i < 3; i++) begin
            drv_val[14] <= 1'b1;
            repeat (4) @(posedge clk);
            drv_val[14] <= 1'b0;
            repeat (4) @(posedge clk);
        end
        rd(RES_BASE + 8'h38, 32'd3);
        wr(CFG_BASE + 8'h3c, 32'h03);
        for (int g = 0; g <= 10; g += 10) begin
            wr(OPT_BASE + 8'h3c, 32'(g));
            repeat ((g == 0 ? 1000 : g) * 20 + 20) @(posedge clk);
            rd(RES_BASE + 8'h3c, 32'd1000);
        end
        wr(CFG_BASE + 8'h3c, 32'h04);
        for (int g = 0; g <= 4; g += 4) begin
            wr(OPT_BASE + 8'h3c, 32'(g));
            repeat (200) @(posedge clk);
            rd(RES_BASE + 8'h3c, 32'd1000);
        end
        wr(TICK_BASE, 32'd3);
        wait_tick(t1);
        wr(TICK_ST_OFS, 32'h1);
        wait_tick(t2);
        chk(32'((t2 - t1) / 100), 32'd30);
        for (int k = 0; k < 4; k++) wr(TICK_BASE + 8'(4 * k), 32'(k + 1));
        repeat (100) @(posedge clk);
        rd(TICK_ST_OFS, 32'hf);
        for (int k = 0; k < 4; k++) wr(TICK_BASE + 8'(4 * k), 32'h0);
        repeat (50) @(posedge clk);
        wr(TICK_ST_OFS, 32'hf);
        repeat (100) @(posedge clk);
        rd(TICK_ST_OFS, 32'h0);
        wr(TICK_BASE + 8'h0c, 32'hffffffff);
        rd(TICK_BASE + 8'h0c, 32'h7fffffff);
        report_and_stop();
    end
endmodule
